/* src/gated_pulse_counter_map.svh */
// Register indices, field positions and reset values of the gated pulse counter
`ifndef GATED_PULSE_COUNTER_MAP_SVH
`define GATED_PULSE_COUNTER_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_W 10
`define IDX_COUNTER_STATUS 10'h140
`define IDX_COUNTER_COMMAND 10'h141
`define IDX_PRESCALER 10'h144
`define IDX_UPPER_LIMIT 10'h145
`define IDX_CURRENT_COUNT 10'h146
`define IDX_IRQ_MASK 10'h148
`define IDX_IRQ_STATUS 10'h149

// Bus geometry
`define ADR_W 12
`define ADR_IDX_LSB 2
`define DAT_W 32
`define SEL_W 4

// Counter status fields
`define STAT_LIMIT_BIT 1

// Command fields
`define CMD_RUN_ENABLE 2'b10
`define CMD_RUN_OFF 2'b00
`define CMD_W 8

// Interrupt status and mask fields
`define IRQ_W 2
`define IRQ_LIMIT_BIT 0
`define IRQ_WRAP_BIT 1

// Widths and reset values
`define CNT_W 32
`define PRESC_W 8
`define CMD_RESET 8'h00
`define PRESC_RESET 8'h00
`define LIMIT_RESET 32'h0000_0000
`define COUNT_RESET 32'h0000_0000
`define COUNT_MAX 32'hffff_ffff
`define IRQ_RESET 2'h0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000
`define BYTE_W 8
`define COUNT_STEP 32'h0000_0001
`define PRESC_STEP 8'h01

`endif

/* src/gated_pulse_counter_pkg.sv */
// Types shared by the gated pulse counter files
package gated_pulse_counter_pkg;

   // Command byte as software writes it
   typedef struct packed {
      logic status_clear;
      logic limit_enable;
      logic gate_high;
      logic rising_edge;
      logic unused3;
      logic gate_enable;
      logic [1:0] run;
   } command_t;

   // Synchronised pin with its edge pulses
   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } pin_edges_t;

endpackage

/* src/pin_edge_sync.sv */
// Two-stage synchroniser with edge detection for one input pin
`timescale 1ns/1ps
`include "gated_pulse_counter_map.svh"

module pin_edge_sync
   import gated_pulse_counter_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic pin_i,
   output pin_edges_t edges_o
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         last_q <= 1'b0;
      else
         last_q <= sync_q;
   end

   always_comb
   begin
      edges_o.level = sync_q;
      edges_o.rise = sync_q & ~last_q;
      edges_o.fall = ~sync_q & last_q;
   end

endmodule

/* src/gated_pulse_counter.sv */
// Gated pulse counter with classic Wishbone register slave
//
// Summary of operation
// - Status bit 1 flags upper limit exceeded
// - Status read-only; only command clears limit flag
// - Run bits 1/0 count; others zero count
// - Count plus one per qualifying edge
// - Command bit 4 picks falling or rising
// - Command bit 2 enables gate input
// - Command bit 5 picks gate active level
// - Command bit 6 limit mode, wraps zero
// - Command bit 7 clears limit flag
// - Prescaler N counts every N pulses; zero stops
// - Readable 32-bit count, writable 32-bit limit
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "gated_pulse_counter_map.svh"

module gated_pulse_counter
   import gated_pulse_counter_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`ADR_W-1:0] wb_adr_i,
   input wire logic [`SEL_W-1:0] wb_sel_i,
   input wire logic [`DAT_W-1:0] wb_dat_i,
   output logic [`DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic count_pulse_input_i,
   input wire logic gate_level_input_i,
   output logic irq_o
);

   // Byte-lane merge for a 32-bit register
   function automatic logic [`DAT_W-1:0] merge_lanes(
      input logic [`DAT_W-1:0] old_val,
      input logic [`DAT_W-1:0] new_val,
      input logic [`SEL_W-1:0] sel
   );
      logic [`DAT_W-1:0] res;
      res = old_val;
      for (int i = 0; i < `SEL_W; i++)
      begin
         if (sel[i])
            res[i*`BYTE_W +: `BYTE_W] = new_val[i*`BYTE_W +: `BYTE_W];
      end
      return res;
   endfunction

   // Register index from a byte address
   function automatic logic [`IDX_W-1:0] reg_index(
      input logic [`ADR_W-1:0] adr
   );
      return adr[`ADR_W-1:`ADR_IDX_LSB];
   endfunction

   // Committed access to one register; byte-wide ones need lane 0
   function automatic logic reg_hit(
      input logic commit,
      input logic [`IDX_W-1:0] at,
      input logic [`IDX_W-1:0] target,
      input logic lane_ok
   );
      return commit & lane_ok & (at == target);
   endfunction

   pin_edges_t pulse_edges;
   pin_edges_t gate_edges;

   command_t command_q;
   logic [`PRESC_W-1:0] presc_q;
   logic [`CNT_W-1:0] limit_q;
   logic [`CNT_W-1:0] count_q;
   logic [`CNT_W-1:0] count_d;
   logic [`PRESC_W-1:0] pre_cnt_q;
   logic [`PRESC_W-1:0] pre_cnt_d;
   logic [`PRESC_W-1:0] pre_next;
   logic limit_flag_q;
   logic [`IRQ_W-1:0] irq_mask_q;
   logic [`IRQ_W-1:0] irq_stat_q;
   logic [`IRQ_W-1:0] irq_events;
   logic [`IRQ_W-1:0] irq_reported;
   logic ack_q;
   logic [`DAT_W-1:0] rdata_q;
   logic [`DAT_W-1:0] rdata_d;

   logic bus_req;
   logic wr_commit;
   logic rd_commit;
   logic [`IDX_W-1:0] idx;
   logic lane0;

   logic running;
   logic gate_open;
   logic edge_seen;
   logic qualified;
   logic step;
   logic limit_hit;
   logic endless_wrap;
   logic cmd_write;
   logic presc_write;
   logic limit_write;
   logic mask_write;
   logic stat_read;
   command_t cmd_wdata;
   logic gate_active;
   logic at_limit;
   logic at_max;

   // Pin synchronisers; pins come from outside the clock domain
   pin_edge_sync pulse_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .pin_i(count_pulse_input_i),
      .edges_o(pulse_edges)
   );

   pin_edge_sync gate_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .pin_i(gate_level_input_i),
      .edges_o(gate_edges)
   );

   // Bus decode
   always_comb
   begin
      bus_req = wb_cyc_i & wb_stb_i;
      idx = reg_index(wb_adr_i);
      lane0 = wb_sel_i[0];
      // Writes and read side effects land on the ack edge only
      wr_commit = bus_req & ack_q & wb_we_i;
      rd_commit = bus_req & ack_q & ~wb_we_i;
      // Byte-wide registers only take lane 0
      cmd_write = reg_hit(wr_commit, idx, `IDX_COUNTER_COMMAND, lane0);
      presc_write = reg_hit(wr_commit, idx, `IDX_PRESCALER, lane0);
      limit_write = reg_hit(wr_commit, idx, `IDX_UPPER_LIMIT, 1'b1);
      mask_write = reg_hit(wr_commit, idx, `IDX_IRQ_MASK, lane0);
      stat_read = reg_hit(rd_commit, idx, `IDX_IRQ_STATUS, 1'b1);
      cmd_wdata = command_t'(wb_dat_i[`CMD_W-1:0]);
   end

   // Ack one cycle after the request, dropped the cycle after
   // One wait state lets read data come from a register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         ack_q <= 1'b0;
      else
         ack_q <= bus_req & ~ack_q;
   end

   // Command register, write only
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         command_q <= `CMD_RESET;
      else if (cmd_write)
         command_q <= cmd_wdata;
   end

   // Prescaler register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         presc_q <= `PRESC_RESET;
      else if (presc_write)
         presc_q <= wb_dat_i[`PRESC_W-1:0];
   end

   // Upper limit register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         limit_q <= `LIMIT_RESET;
      else if (limit_write)
         limit_q <= merge_lanes(limit_q, wb_dat_i, wb_sel_i);
   end

   // Interrupt mask register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         irq_mask_q <= `IRQ_RESET;
      else if (mask_write)
         irq_mask_q <= wb_dat_i[`IRQ_W-1:0];
   end

   // Qualification of pulse edges
   always_comb
   begin
      running = (command_q.run == `CMD_RUN_ENABLE);
      // Rising or falling edge per bit 4
      edge_seen = command_q.rising_edge ? pulse_edges.rise : pulse_edges.fall;
      // Gate compares synchronised level against selected level
      gate_active = (gate_edges.level == command_q.gate_high);
      gate_open = ~command_q.gate_enable | gate_active;
      // Zero prescaler drops pulses altogether
      qualified = running & edge_seen & gate_open & (presc_q != `PRESC_RESET);
   end

   // Prescaler step decision
   always_comb
   begin
      pre_next = pre_cnt_q + `PRESC_STEP;
      // Compare with >= so a lowered prescaler still steps
      step = qualified & (pre_next >= presc_q);
      pre_cnt_d = pre_cnt_q;
      if (~running)
         pre_cnt_d = `PRESC_RESET;
      else if (step)
         pre_cnt_d = `PRESC_RESET;
      else if (qualified)
         pre_cnt_d = pre_next;
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         pre_cnt_q <= `PRESC_RESET;
      else
         pre_cnt_q <= pre_cnt_d;
   end

   // Count value update
   always_comb
   begin
      // Exceeding means stepping past the limit value
      // A limit lowered below the count wraps at the next step
      at_limit = (count_q >= limit_q);
      at_max = (count_q == `COUNT_MAX);
      limit_hit = step & command_q.limit_enable & at_limit;
      endless_wrap = step & ~command_q.limit_enable & at_max;
      count_d = count_q;
      if (~running)
         count_d = `COUNT_RESET;
      else if (limit_hit)
         count_d = `COUNT_RESET;
      else if (step)
         count_d = count_q + `COUNT_STEP;
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         count_q <= `COUNT_RESET;
      else
         count_q <= count_d;
   end

   // Limit-exceeded flag; a hit in the clearing cycle wins
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         limit_flag_q <= 1'b0;
      else if (limit_hit)
         limit_flag_q <= 1'b1;
      else if (cmd_write & cmd_wdata.status_clear)
         limit_flag_q <= 1'b0;
   end

   // Interrupt events
   always_comb
   begin
      irq_events = `IRQ_RESET;
      irq_events[`IRQ_LIMIT_BIT] = limit_hit;
      irq_events[`IRQ_WRAP_BIT] = endless_wrap;
      // Clear only what the read returned; later events must survive
      irq_reported = rdata_q[`IRQ_W-1:0];
   end

   // Sticky interrupt status, cleared by reading it; events win
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         irq_stat_q <= `IRQ_RESET;
      else if (stat_read)
         irq_stat_q <= (irq_stat_q & ~irq_reported) | irq_events;
      else
         irq_stat_q <= irq_stat_q | irq_events;
   end

   always_comb
   begin
      irq_o = |(irq_stat_q & irq_mask_q);
   end

   // Read data mux; unmapped and write-only read as zero
   always_comb
   begin
      rdata_d = `WORD_ZERO;
      unique case (idx)
         `IDX_COUNTER_STATUS:
         begin
            rdata_d[`STAT_LIMIT_BIT] = limit_flag_q;
         end
         `IDX_PRESCALER:
         begin
            rdata_d[`PRESC_W-1:0] = presc_q;
         end
         `IDX_UPPER_LIMIT:
         begin
            rdata_d = limit_q;
         end
         `IDX_CURRENT_COUNT:
         begin
            rdata_d = count_q;
         end
         `IDX_IRQ_MASK:
         begin
            rdata_d[`IRQ_W-1:0] = irq_mask_q;
         end
         `IDX_IRQ_STATUS:
         begin
            rdata_d[`IRQ_W-1:0] = irq_stat_q;
         end
         default:
         begin
            rdata_d = `WORD_ZERO;
         end
      endcase
   end

   // Read data sampled on the request edge, held through ack
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         rdata_q <= `WORD_ZERO;
      else if (bus_req & ~ack_q & ~wb_we_i)
         rdata_q <= rdata_d;
   end

   always_comb
   begin
      wb_ack_o = ack_q;
      wb_dat_o = rdata_q;
   end

endmodule

/* tb/gated_pulse_counter_assertions.sv */
// Bus and interrupt assertions for the gated pulse counter
`timescale 1ns/1ps
`include "gated_pulse_counter_map.svh"

module gated_pulse_counter_assertions (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`ADR_W-1:0] wb_adr_i,
   input wire logic [`SEL_W-1:0] wb_sel_i,
   input wire logic [`DAT_W-1:0] wb_dat_i,
   input wire logic [`DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o
);
   logic [`IDX_W-1:0] idx;
   logic [7:0] cmd_q;
   logic [1:0] mask_q;
   assign idx = wb_adr_i[`ADR_W-1:`ADR_IDX_LSB];
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // Shadows taken at the committing edge, as the slave does
   always_ff @(posedge core_clk_i or posedge reset_i)
      if (reset_i)
         cmd_q <= 8'h00;
      else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == `IDX_COUNTER_COMMAND)
         cmd_q <= wb_dat_i[7:0];
   always_ff @(posedge core_clk_i or posedge reset_i)
      if (reset_i)
         mask_q <= 2'h0;
      else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == `IDX_IRQ_MASK)
         mask_q <= wb_dat_i[1:0];
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(logic [`IDX_W-1:0] i);
      wb_ack_o && !wb_we_i && idx == i;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_hole_zero: assert property (s_rd(10'h3ff) |-> wb_dat_o == '0) else $error("hole read");
   a_command_hidden: assert property (s_rd(`IDX_COUNTER_COMMAND) |-> wb_dat_o == '0)
      else $error("command read");
   a_status_layout: assert property (s_rd(`IDX_COUNTER_STATUS) |-> wb_dat_o[0] == 1'b0
      && wb_dat_o[31:2] == '0) else $error("status layout");
   a_stopped_zero: assert property (s_rd(`IDX_CURRENT_COUNT) ##0 cmd_q[1:0] != 2'b10
      |-> wb_dat_o == '0) else $error("stopped count");
   a_irq_fall_access: assert property ($fell(irq_o) |-> $past(wb_ack_o)) else $error("irq fell");
   a_irq_masked: assert property (irq_o |-> mask_q != 2'h0) else $error("irq unmasked");
endmodule

bind gated_pulse_counter gated_pulse_counter_assertions chk (
   .core_clk_i(core_clk_i),
   .reset_i(reset_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .irq_o(irq_o)
);

/* tb/pulse_source_model.sv */
// Pulse source that plays a burst of edges onto the count pin
`timescale 1ns/1ps

module pulse_source_model (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [4:0] edges_i,
   input wire logic [3:0] half_i,
   output logic pulse_o,
   output logic busy_o
);
   logic [4:0] left_q;
   logic [3:0] tick_q;
   assign busy_o = left_q != 5'h00;
   // Half period is half_i+1 clocks; even one clock is long enough for the synchroniser to see every edge
   always_ff @(posedge core_clk_i or posedge reset_i)
      if (reset_i)
      begin
         left_q <= 5'h00;
         tick_q <= 4'h0;
         pulse_o <= 1'b0;
      end
      else if (start_i)
      begin
         left_q <= edges_i;
         tick_q <= half_i;
      end
      else if (busy_o)
      begin
         tick_q <= (tick_q == 4'h0) ? half_i : tick_q - 4'h1;
         if (tick_q == 4'h0)
         begin
            pulse_o <= !pulse_o;
            left_q <= left_q - 5'h01;
         end
      end
endmodule

/* tb/test_gated_pulse_counter.sv */
// Register-level test of the gated pulse counter
`timescale 1ns/1ps
`include "gated_pulse_counter_map.svh"

module test_gated_pulse_counter;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic gate = 1'b0;
   logic start = 1'b0;
   logic [4:0] edges = 5'h00;
   logic [3:0] half = 4'h2;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat, rdat;
   logic ack, pin, irq, busy;
   int errors = 0;
   int checked = 0;
   int i;
   logic [7:0] cmds [12] = '{8'h12, 8'h02, 8'h16, 8'h16, 8'h36, 8'h36, 8'h26, 8'h06,
      8'h13, 8'h11, 8'h10, 8'h32};
   logic gates [12] = '{0, 0, 1, 0, 0, 1, 1, 1, 0, 0, 0, 0};
   logic [31:0] exps [12] = '{4, 3, 0, 4, 0, 4, 3, 0, 0, 0, 0, 4};
   logic [11:0] regs [8] = '{12'h500, 12'h504, 12'h510, 12'h514, 12'h518, 12'h520, 12'h524,
      12'hffc};

   gated_pulse_counter gated_pulse_counter_inst (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .wb_cyc_i(cyc),
      .wb_stb_i(cyc),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(sel),
      .wb_dat_i(wdat),
      .wb_dat_o(dat),
      .wb_ack_o(ack),
      .count_pulse_input_i(pin),
      .gate_level_input_i(gate),
      .irq_o(irq)
   );
   pulse_source_model pulse_source_model_inst (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .start_i(start),
      .edges_i(edges),
      .half_i(half),
      .pulse_o(pin),
      .busy_o(busy)
   );

   initial
      forever #12.5 core_clk_i = !core_clk_i;

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Interrupt level is taken one edge after the access that moves it
   task automatic check_irq(logic exp);
      @(posedge core_clk_i);
      check("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   task automatic conclude;
      $display("Counts: %0d compared, %0d mismatched", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic access(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      int n;
      @(posedge core_clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rdat = dat;
      cyc <= 1'b0;
      if (ack !== 1'b1)
      begin
         check("ack", 1, 0);
         conclude();
      end
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      access(1'b1, a, d, 4'hf);
   endtask

   task automatic rd(logic [11:0] a, logic [31:0] exp);
      access(1'b0, a, 32'h0, 4'hf);
      check($sformatf("reg %h", a), exp, rdat);
   endtask

   // Fixed tail covers sync and count latency
   task automatic play(logic [4:0] n);
      int k;
      @(posedge core_clk_i);
      start <= 1'b1;
      edges <= n;
      @(posedge core_clk_i);
      start <= 1'b0;
      for (k = 0; k < 600 && (busy || k < 2); k++)
         @(posedge core_clk_i);
      if (busy)
      begin
         check("burst", 0, 1);
         conclude();
      end
      repeat (6) @(posedge core_clk_i);
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      wr(12'h500, 32'hffff_ffff);
      wr(12'h518, 32'h0000_00ff);
      for (i = 0; i < 8; i++)
         rd(regs[i], 32'h0);
      wr(12'h514, 32'h1234_5678);
      access(1'b1, 12'h514, 32'hffff_ffff, 4'h1);
      rd(12'h514, 32'h1234_56ff);
      wr(12'h510, 32'h0000_01ff);
      rd(12'h510, 32'h0000_00ff);
      $display("Register test done");
      wr(12'h510, 32'h1);
      for (i = 0; i < 12; i++)
      begin
         wr(12'h504, 32'h0);
         wr(12'h504, {24'h0, cmds[i]});
         gate <= gates[i];
         play(5'd7);
         rd(12'h518, exps[i]);
         play(5'd1);
      end
      $display("Edge and gate test done");
      half <= 4'h9;
      wr(12'h504, 32'h0);
      wr(12'h504, 32'h12);
      wr(12'h510, 32'h3);
      play(5'd14);
      rd(12'h518, 32'h2);
      wr(12'h510, 32'h0);
      play(5'd4);
      rd(12'h518, 32'h2);
      $display("Prescaler test done");
      half <= 4'h1;
      wr(12'h510, 32'h1);
      wr(12'h514, 32'h3);
      wr(12'h520, 32'h1);
      wr(12'h504, 32'h0);
      wr(12'h504, 32'h52);
      play(5'd8);
      rd(12'h518, 32'h0);
      check_irq(1'b1);
      rd(12'h500, 32'h2);
      wr(12'h504, 32'h52);
      rd(12'h500, 32'h2);
      rd(12'h524, 32'h1);
      check_irq(1'b0);
      rd(12'h524, 32'h0);
      wr(12'h504, 32'h80);
      rd(12'h500, 32'h0);
      wr(12'h520, 32'h0);
      wr(12'h504, 32'h52);
      play(5'd8);
      check_irq(1'b0);
      wr(12'h520, 32'h1);
      check_irq(1'b1);
      rd(12'h524, 32'h1);
      wr(12'h504, 32'h80);
      wr(12'h504, 32'h12);
      play(5'd8);
      rd(12'h518, 32'h4);
      rd(12'h500, 32'h0);
      $display("Limit test done");
      conclude();
   end
endmodule
